// File: rtl/ddsm_defs.svh
// constants for the dds mode and modulation control block
// assumes inclusion by bare name from package and design files
`ifndef DDSM_DEFS_SVH
`define DDSM_DEFS_SVH
// register word offsets (byte address = index * 4)
`define DDSM_IDX_CSEL      6'h00
`define DDSM_IDX_FCFG1     6'h01
`define DDSM_IDX_FCFG2     6'h02
`define DDSM_IDX_CFUNC     6'h03
`define DDSM_IDX_FREQ0     6'h04
`define DDSM_IDX_PHASE0    6'h05
`define DDSM_IDX_AMP0      6'h06
`define DDSM_IDX_RAMPRATE  6'h07
`define DDSM_IDX_PROF1     6'h0a
`define DDSM_IDX_PROF15    6'h18
`define DDSM_IDX_AUXFREQ   6'h19
`define DDSM_IDX_AUXAMP    6'h1a
`define DDSM_IDX_STATUS    6'h1b
// function_config_one fields
`define DDSM_F1_TESTTONE   2
`define DDSM_F1_PDMODE     6
`define DDSM_F1_LVL_LO     8
`define DDSM_F1_RMP_LO     10
`define DDSM_F1_PPC_LO     12
`define DDSM_F1_CP_LO      16
`define DDSM_F1_MUL_LO     18
`define DDSM_F1_VCOHI      23
// channel_function_reg fields
`define DDSM_CF_PD_LO      4
`define DDSM_CF_DAC_LO     8
`define DDSM_CF_MOD_LO     22
// channel_select_reg fields
`define DDSM_CS_AUX_EN_LO  4
`define DDSM_CS_SYNC_EN    0
// multiplier range and defaults
`define DDSM_MUL_MIN       5'h04
`define DDSM_MUL_MAX       5'h14
`define DDSM_CP_DEFAULT    2'h0
`define DDSM_AMP_FULL      10'h3ff
`define DDSM_RAMP_DIV      16'h0010
`define DDSM_ZERO32        32'h0000_0000
`endif

// File: rtl/ddsm_pkg.sv
// types for the dds mode and modulation control block
// assumes ddsm_defs.svh is on the include path
package ddsm_pkg;
	typedef enum logic [1:0] {
		DDSM_MOD_OFF,
		DDSM_MOD_AMP,
		DDSM_MOD_FREQ,
		DDSM_MOD_PHASE
	} ddsm_mod_t;
	typedef enum logic [1:0] {
		DDSM_RAMP_HOLD,
		DDSM_RAMP_UP,
		DDSM_RAMP_DOWN
	} ddsm_ramp_t;
	typedef struct packed {
		logic [31:0] freq;
		logic [13:0] phase;
		logic [9:0]  amp;
	} ddsm_word_t;
	typedef struct packed {
		logic       clk_in_pd;
		logic       dac_pd;
		logic       main_pd;
		logic       aux_pd;
	} ddsm_pd_t;
	typedef struct packed {
		logic        pll_en;
		logic [4:0]  pll_mult;
		logic        vco_high;
		logic [1:0]  cp_sel;
		logic        xtal_en;
	} ddsm_clk_t;
endpackage

// File: rtl/ddsm_ctrl.sv
// control logic of a single-output dds: modulation, clocks, power-down
// assumes avalon-mm master on clock; pins async, profile and serial pins sampled on sync clock
//
// How it works
// RULE_01 - function_config_one bit 2 enables test-tone amplitude modulation of primary channel.
// RULE_02 - host disables auxiliary channels two and three during test-tone mode.
// RULE_03 - test-tone rate comes from auxiliary_channel_zero 32-bit tuning word.
// RULE_04 - test-tone depth comes from auxiliary_channel_zero 10-bit scale bits 9..0.
// RULE_05 - multiplier factor is function_config_one bits 22..18.
// RULE_06 - factor 4..20 enables multiplier; otherwise bypass, reference rate used.
// RULE_07 - function_config_one bit 23 picks low or high vco range.
// RULE_08 - charge pump defaults to 75 uA; bits 17..16 change it.
// RULE_09 - clock mode select high enables crystal oscillator, low external clock.
// RULE_10 - channel function bits 9..8 scale dac current: 11,01,10,00 = 1,1/2,1/4,1/8.
// RULE_11 - clock input, dac, primary and auxiliary logic power down separately.
// RULE_12 - power_down_pin high applies mode from function_config_one bit 6.
// RULE_13 - power_down_pin low applies channel function bits 7..4.
// RULE_14 - host keeps sync clock on and auxiliaries off during keying.
// RULE_15 - channel function bits 23..22: off, amplitude, frequency, phase.
// RULE_16 - sixteen primary profiles; profile 0 at 0x04..0x06, others 0x0a..0x18.
// RULE_17 - words 32/14/10 bits; phase and amplitude taken msb-aligned.
// RULE_18 - function_config_one bits 9..8 select 2, 4, 8 or 16 levels.
// RULE_19 - host keeps linear sweep enable clear while keying.
// RULE_20 - bits 11..10 pick ramp pin: none, p2/p3, p3, serial pins.
// RULE_21 - ramp pin low ramps amplitude up, high ramps it down.
// RULE_22 - ramping steps the 10-bit output scale factor.
// RULE_23 - profile pins form binary index, pin zero least significant; code takes pin 1 alone in 2-level mode.
// RULE_24 - pins sampled on sync clock edge; new word after fixed latency.
`timescale 1ns/1ns
`include "ddsm_defs.svh"
module ddsm_ctrl (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              reset_n,
	// avalon-mm slave
	input  wire logic [7:0]        address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	output logic [31:0]            readdata,
	output logic                   waitrequest,
	// device pins
	input  wire logic              sync_clk_pin,
	input  wire logic [3:0]        profile_pin,
	input  wire logic              power_down_pin,
	input  wire logic              clk_mode_sel_pin,
	input  wire logic [3:1]        serial_data_pin,
	// outputs to datapath and analog
	output ddsm_pkg::ddsm_word_t   primary_word,
	output ddsm_pkg::ddsm_mod_t    mod_type,
	output ddsm_pkg::ddsm_pd_t     power_down,
	output ddsm_pkg::ddsm_clk_t    clk_cfg,
	output logic [3:0]             dac_scale_onehot,
	output logic                   test_tone_en,
	output logic [31:0]            test_tone_rate,
	output logic [9:0]             test_tone_depth,
	output logic                   serial_one_bit_only
);
	// register file
	logic [31:0] csel_reg, fcfg1_reg, fcfg2_reg, cfunc_reg;
	logic [31:0] ramprate_reg, auxfreq_reg, auxamp_reg;
	logic [31:0] freq_reg  [16];
	logic [31:0] phase_reg [16];
	logic [31:0] amp_reg   [16];
	logic        wait_reg;
	logic [31:0] rdata_reg;
	logic [9:0]  scale_reg, scale_next;

	// pin synchronisers
	logic [3:0] prof_s1_reg, prof_s2_reg;
	logic [2:0] sd_s1_reg, sd_s2_reg;
	logic       sclk_s1_reg, sclk_s2_reg, sclk_d_reg;
	logic       pdp_s1_reg, pdp_s2_reg;
	logic       cms_s1_reg, cms_s2_reg;

	// address decode
	wire  [5:0] idx      = address[7:2];
	wire        in_prof  = (idx >= `DDSM_IDX_PROF1) && (idx <= `DDSM_IDX_PROF15);
	wire  [3:0] prof_sel = 4'(idx - `DDSM_IDX_PROF1 + 6'h01);
	wire        wr_go    = write && wait_reg == 1'b0;
	// read data loaded as waitrequest drops, so it stands at the accepting edge
	wire        rd_go    = read && wait_reg == 1'b1;

	// one wait state, answer on the second edge of a request
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			wait_reg <= 1'b1;
		else if ((read || write) && wait_reg)
			wait_reg <= 1'b0;
		else
			wait_reg <= 1'b1;
	end

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = `DDSM_ZERO32;
		case (idx)
			`DDSM_IDX_CSEL:     rd_mux = csel_reg;
			`DDSM_IDX_FCFG1:    rd_mux = fcfg1_reg;
			`DDSM_IDX_FCFG2:    rd_mux = fcfg2_reg;
			`DDSM_IDX_CFUNC:    rd_mux = cfunc_reg;
			`DDSM_IDX_FREQ0:    rd_mux = freq_reg[0];
			`DDSM_IDX_PHASE0:   rd_mux = phase_reg[0];
			`DDSM_IDX_AMP0:     rd_mux = amp_reg[0];
			`DDSM_IDX_RAMPRATE: rd_mux = ramprate_reg;
			`DDSM_IDX_AUXFREQ:  rd_mux = auxfreq_reg;
			`DDSM_IDX_AUXAMP:   rd_mux = auxamp_reg;
			`DDSM_IDX_STATUS:   rd_mux = {16'h0000, 6'h00, scale_reg};
			default: begin
				if (in_prof)
					rd_mux = freq_reg[prof_sel];
			end
		endcase
	end

	// profile words 1..15 hold one 32-bit word; its use follows the modulation type
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			csel_reg     <= `DDSM_ZERO32;
			fcfg1_reg    <= `DDSM_ZERO32; // [RULE_08]
			fcfg2_reg    <= `DDSM_ZERO32;
			cfunc_reg    <= `DDSM_ZERO32;
			ramprate_reg <= `DDSM_ZERO32;
			auxfreq_reg  <= `DDSM_ZERO32;
			auxamp_reg   <= `DDSM_ZERO32;
			rdata_reg    <= `DDSM_ZERO32;
			for (int i = 0; i < 16; i++) begin
				freq_reg[i]  <= `DDSM_ZERO32;
				phase_reg[i] <= `DDSM_ZERO32;
				amp_reg[i]   <= `DDSM_ZERO32;
			end
		end else begin
			if (rd_go)
				rdata_reg <= rd_mux;
			if (wr_go) begin
				case (idx)
					`DDSM_IDX_CSEL:     csel_reg     <= writedata;
					`DDSM_IDX_FCFG1:    fcfg1_reg    <= writedata;
					`DDSM_IDX_FCFG2:    fcfg2_reg    <= writedata;
					`DDSM_IDX_CFUNC:    cfunc_reg    <= writedata;
					`DDSM_IDX_FREQ0:    freq_reg[0]  <= writedata; // [RULE_16]
					`DDSM_IDX_PHASE0:   phase_reg[0] <= writedata;
					`DDSM_IDX_AMP0:     amp_reg[0]   <= writedata;
					`DDSM_IDX_RAMPRATE: ramprate_reg <= writedata;
					`DDSM_IDX_AUXFREQ:  auxfreq_reg  <= writedata;
					`DDSM_IDX_AUXAMP:   auxamp_reg   <= writedata;
					default: begin
						if (in_prof) begin
							freq_reg[prof_sel]  <= writedata; // [RULE_16]
							phase_reg[prof_sel] <= writedata;
							amp_reg[prof_sel]   <= writedata;
						end
					end
				endcase
			end
		end
	end
	assign readdata    = rdata_reg;
	assign waitrequest = wait_reg;

	// two-flop synchronisers for every pin
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prof_s1_reg <= 4'h0;
			prof_s2_reg <= 4'h0;
			sd_s1_reg   <= 3'h0;
			sd_s2_reg   <= 3'h0;
			sclk_s1_reg <= 1'b0;
			sclk_s2_reg <= 1'b0;
			sclk_d_reg  <= 1'b0;
			pdp_s1_reg  <= 1'b0;
			pdp_s2_reg  <= 1'b0;
			cms_s1_reg  <= 1'b0;
			cms_s2_reg  <= 1'b0;
		end else begin
			prof_s1_reg <= profile_pin;
			prof_s2_reg <= prof_s1_reg;
			sd_s1_reg   <= serial_data_pin;
			sd_s2_reg   <= sd_s1_reg;
			sclk_s1_reg <= sync_clk_pin;
			sclk_s2_reg <= sclk_s1_reg;
			sclk_d_reg  <= sclk_s2_reg;
			pdp_s1_reg  <= power_down_pin;
			pdp_s2_reg  <= pdp_s1_reg;
			cms_s1_reg  <= clk_mode_sel_pin;
			cms_s2_reg  <= cms_s2_reg ^ (cms_s1_reg ^ cms_s2_reg);
		end
	end
	wire sync_rise = sclk_s2_reg && !sclk_d_reg;

	// configuration decode
	wire [1:0] level_sel = fcfg1_reg[`DDSM_F1_LVL_LO +: 2];      // [RULE_18]
	wire [1:0] ramp_src  = fcfg1_reg[`DDSM_F1_RMP_LO +: 2];      // [RULE_20]
	wire [2:0] profile_pin_assignment       = fcfg1_reg[`DDSM_F1_PPC_LO +: 3];
	wire [4:0] mult      = fcfg1_reg[`DDSM_F1_MUL_LO +: 5];      // [RULE_05]
	wire       pll_on    = mult >= `DDSM_MUL_MIN && mult <= `DDSM_MUL_MAX; // [RULE_06]
	wire [1:0] mod_sel   = cfunc_reg[`DDSM_CF_MOD_LO +: 2];      // [RULE_15]
	wire [1:0] dac_sel   = cfunc_reg[`DDSM_CF_DAC_LO +: 2];
	wire [3:0] cf_pd     = cfunc_reg[`DDSM_CF_PD_LO +: 4];

	// profile index from pins, pin zero as lsb except 2-level mode (pin 1 alone); ppc picks pin pair
	logic [3:0] pidx;
	logic       ramp_pin_valid;
	logic       ramp_level;
	always_comb begin
		pidx = 4'h0;
		ramp_pin_valid = 1'b0;
		ramp_level = 1'b0;
		case (level_sel)
			2'b00: pidx = {3'b000, prof_s2_reg[1]};
			2'b01: pidx = (profile_pin_assignment == 3'b000) ? {2'b00, prof_s2_reg[3:2]}
			                              : {2'b00, prof_s2_reg[1:0]};
			2'b10: pidx = {1'b0, prof_s2_reg[2:0]};
			default: pidx = prof_s2_reg;                         // [RULE_23]
		endcase
		case (ramp_src)
			2'b01: begin
				ramp_pin_valid = 1'b1;
				ramp_level = (profile_pin_assignment == 3'b000) ? prof_s2_reg[3] : prof_s2_reg[2];
				pidx = (profile_pin_assignment == 3'b000) ? {3'b000, prof_s2_reg[1]}
				                       : {3'b000, prof_s2_reg[0]};
			end
			2'b10: begin
				ramp_pin_valid = 1'b1;
				ramp_level = prof_s2_reg[3];
				pidx = {1'b0, prof_s2_reg[2:0]};
			end
			2'b11: begin
				ramp_pin_valid = 1'b1;
				ramp_level = (level_sel == 2'b01 && profile_pin_assignment == 3'b000) ? sd_s2_reg[1]
				                                                   : sd_s2_reg[0];
			end
			default: ramp_pin_valid = 1'b0;
		endcase
	end

	// pins latched on sync clock rising edge, applied one clock later
	logic [3:0] pidx_reg;
	logic       ramp_dn_reg;
	ddsm_pkg::ddsm_ramp_t ramp_state;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pidx_reg    <= 4'h0;
			ramp_dn_reg <= 1'b0;
		end else if (sync_rise) begin
			pidx_reg    <= pidx;                                 // [RULE_24]
			ramp_dn_reg <= ramp_level;
		end
	end
	always_comb begin
		case ({ramp_pin_valid, ramp_dn_reg})
			2'b10:   ramp_state = ddsm_pkg::DDSM_RAMP_UP;        // [RULE_21]
			2'b11:   ramp_state = ddsm_pkg::DDSM_RAMP_DOWN;
			default: ramp_state = ddsm_pkg::DDSM_RAMP_HOLD;
		endcase
	end

	// ramp engine steps the scale factor, limited by the amp word
	logic [15:0] rdiv_reg;
	wire  [9:0]  amp_top  = amp_reg[0][9:0];
	wire         rtick    = rdiv_reg == 16'h0000;
	always_comb begin
		scale_next = scale_reg;
		case (ramp_state)
			ddsm_pkg::DDSM_RAMP_UP:
				if (rtick && scale_reg < amp_top)
					scale_next = scale_reg + 10'h001;         // [RULE_22]
			ddsm_pkg::DDSM_RAMP_DOWN:
				if (rtick && scale_reg != 10'h000)
					scale_next = scale_reg - 10'h001;
			default: scale_next = amp_top;
		endcase
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			scale_reg <= 10'h000;
			rdiv_reg  <= `DDSM_RAMP_DIV;
		end else begin
			scale_reg <= scale_next;
			rdiv_reg  <= rtick ? (ramprate_reg[15:0] | 16'h0001) : rdiv_reg - 16'h0001;
		end
	end

	// output word selection, msb-aligned phase and amplitude
	logic [31:0] pf, pp, pa;
	ddsm_pkg::ddsm_word_t word_next;
	always_comb begin
		pf = freq_reg[pidx_reg];
		pp = (pidx_reg == 4'h0) ? {phase_reg[0][13:0], 18'h00000} : phase_reg[pidx_reg];
		pa = (pidx_reg == 4'h0) ? {amp_reg[0][9:0], 22'h000000} : amp_reg[pidx_reg];
		word_next.freq  = freq_reg[0];
		word_next.phase = phase_reg[0][13:0];
		word_next.amp   = ramp_pin_valid ? scale_reg : amp_reg[0][9:0];
		case (mod_sel)
			2'b01: word_next.amp   = pa[31:22];                  // [RULE_17]
			2'b10: word_next.freq  = pf;
			2'b11: word_next.phase = pp[31:18];                  // [RULE_17]
			default: word_next.freq = freq_reg[0];
		endcase
	end

	// power-down: pin selects between fcfg1 mode bit and individual bits
	ddsm_pkg::ddsm_pd_t pd_next;
	wire pd_full = fcfg1_reg[`DDSM_F1_PDMODE];
	always_comb begin
		if (pdp_s2_reg)
			pd_next = pd_full ? 4'b1111 : 4'b0111;              // [RULE_12]
		else
			pd_next = cf_pd;                                     // [RULE_11] [RULE_13]
	end

	// output registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			primary_word        <= '0;
			mod_type            <= ddsm_pkg::DDSM_MOD_OFF;
			power_down          <= '0;
			clk_cfg             <= '0;
			dac_scale_onehot    <= 4'h0;
			test_tone_en        <= 1'b0;
			test_tone_rate      <= `DDSM_ZERO32;
			test_tone_depth     <= 10'h000;
			serial_one_bit_only <= 1'b0;
		end else begin
			primary_word        <= word_next;
			mod_type            <= ddsm_pkg::ddsm_mod_t'(mod_sel);      // [RULE_15]
			power_down          <= pd_next;
			clk_cfg.pll_en      <= pll_on;                              // [RULE_06]
			clk_cfg.pll_mult    <= pll_on ? mult : 5'h01;               // [RULE_05]
			clk_cfg.vco_high    <= fcfg1_reg[`DDSM_F1_VCOHI];          // [RULE_07]
			clk_cfg.cp_sel      <= fcfg1_reg[`DDSM_F1_CP_LO +: 2];     // [RULE_08]
			clk_cfg.xtal_en     <= cms_s2_reg;                          // [RULE_09]
			case (dac_sel)                                              // [RULE_10]
				2'b11:   dac_scale_onehot <= 4'b1000;
				2'b01:   dac_scale_onehot <= 4'b0100;
				2'b10:   dac_scale_onehot <= 4'b0010;
				default: dac_scale_onehot <= 4'b0001;
			endcase
			test_tone_en        <= fcfg1_reg[`DDSM_F1_TESTTONE];       // [RULE_01]
			test_tone_rate      <= auxfreq_reg;                         // [RULE_03]
			test_tone_depth     <= auxamp_reg[9:0];                     // [RULE_04]
			serial_one_bit_only <= ramp_src == 2'b11;                   // [RULE_20]
		end
	end
endmodule

// File: sim/ddsm_ctrl_properties.sv
// port checker for the dds control block
// assumes binding onto ddsm_ctrl, single clock domain
`timescale 1ns/1ns
module ddsm_ctrl_properties (
	// clock and reset
	input wire logic            clock,
	input wire logic            reset_n,
	// register bus
	input wire logic [7:0]      address,
	input wire logic            read,
	input wire logic            write,
	input wire logic            waitrequest,
	// pins and outputs
	input wire logic            power_down_pin,
	input wire logic            clk_mode_sel_pin,
	input ddsm_pkg::ddsm_mod_t  mod_type,
	input ddsm_pkg::ddsm_pd_t   power_down,
	input ddsm_pkg::ddsm_clk_t  clk_cfg,
	input wire logic [3:0]      dac_scale_onehot,
	input wire logic            test_tone_en
);
	wire fcfg1_wr = write && !waitrequest && address[7:2] == 6'h01;
	wire cfunc_wr = write && !waitrequest && address[7:2] == 6'h03;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	chk_read_answer: assert property ($rose(read) |=> !waitrequest)
		else $error("read not answered after one wait state");
	chk_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_pll_range: assert property (clk_cfg.pll_en |-> clk_cfg.pll_mult inside {[5'h04:5'h14]})
		else $error("multiplier enabled outside 4 to 20");
	chk_xtal_follow: assert property ($stable(clk_mode_sel_pin) [*6] |-> clk_cfg.xtal_en == clk_mode_sel_pin)
		else $error("crystal enable does not follow mode pin");
	chk_dac_onehot: assert property (reset_n [*3] |-> $onehot(dac_scale_onehot))
		else $error("dac scale not one-hot");
	chk_pd_pin: assert property (power_down_pin [*6] |-> power_down.dac_pd && power_down.main_pd && power_down.aux_pd)
		else $error("pin power-down not applied");
	chk_tone_cause: assert property ($changed(test_tone_en) |-> $past(fcfg1_wr) || $past(fcfg1_wr, 2))
		else $error("test tone changed without config write");
	chk_mod_cause: assert property ($changed(mod_type) |-> $past(cfunc_wr) || $past(cfunc_wr, 2))
		else $error("modulation type changed without write");
endmodule
bind ddsm_ctrl ddsm_ctrl_properties i_props (.clock(clock), .reset_n(reset_n), .address(address),
	.read(read), .write(write), .waitrequest(waitrequest), .power_down_pin(power_down_pin),
	.clk_mode_sel_pin(clk_mode_sel_pin), .mod_type(mod_type), .power_down(power_down),
	.clk_cfg(clk_cfg), .dac_scale_onehot(dac_scale_onehot), .test_tone_en(test_tone_en));

// File: sim/ddsm_host_model.sv
// host-side model: sync clock and device pins
// assumes pin requests come from the bench
`timescale 1ns/1ns
module ddsm_host_model (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       reset_n,
	// requests from the bench
	input  wire logic [3:0] profile_req,
	input  wire logic       pd_req,
	input  wire logic       xtal_req,
	input  wire logic [3:1] serial_req,
	// device pins
	output logic            sync_clk_pin,
	output logic [3:0]      profile_pin,
	output logic            power_down_pin,
	output logic            clk_mode_sel_pin,
	output logic [3:1]      serial_data_pin
);
	logic [1:0] div_reg;
	// sync clock kept running while keying
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			div_reg <= 2'h0;
		end else begin
			div_reg <= div_reg + 2'h1;
		end
	end
	assign sync_clk_pin = div_reg[1];
	// profile and serial pins move on sync falls so they are settled at each rise
	always_ff @(negedge sync_clk_pin or negedge reset_n) begin
		if (!reset_n) begin
			profile_pin <= 4'h0;
			serial_data_pin <= 3'h0;
		end else begin
			profile_pin <= profile_req;
			serial_data_pin <= serial_req;
		end
	end
	assign power_down_pin = pd_req;
	assign clk_mode_sel_pin = xtal_req;
endmodule

// File: sim/ddsm_ctrl_tb.sv
// self-checking bench for the dds control block
// assumes the host model on the pins and the bound checker
`timescale 1ns/1ns
module ddsm_ctrl_tb;
	logic                 clock, reset_n, read, write, waitrequest, exp_en;
	logic [7:0]           address;
	logic [31:0]          writedata, readdata, rd, test_tone_rate;
	logic                 sync_clk_pin, power_down_pin, clk_mode_sel_pin, pd_req, xtal_req;
	logic                 test_tone_en, serial_one_bit_only;
	logic [3:0]           profile_req, profile_pin, dac_scale_onehot;
	logic [3:1]           serial_req, serial_data_pin;
	logic [9:0]           test_tone_depth;
	logic [4:0]           mults [4] = '{5'h03, 5'h04, 5'h14, 5'h15};
	logic [3:0]           dac_exp [4] = '{4'h1, 4'h4, 4'h2, 4'h8};
	logic [3:0]           sel [4] = '{4'h0, 4'h1, 4'he, 4'hf};
	ddsm_pkg::ddsm_word_t primary_word;
	ddsm_pkg::ddsm_mod_t  mod_type;
	ddsm_pkg::ddsm_pd_t   power_down;
	ddsm_pkg::ddsm_clk_t  clk_cfg;
	int                   miscompares, checks;
	ddsm_ctrl i_dut (.clock(clock), .reset_n(reset_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.sync_clk_pin(sync_clk_pin), .profile_pin(profile_pin), .power_down_pin(power_down_pin),
		.clk_mode_sel_pin(clk_mode_sel_pin), .serial_data_pin(serial_data_pin),
		.primary_word(primary_word), .mod_type(mod_type), .power_down(power_down),
		.clk_cfg(clk_cfg), .dac_scale_onehot(dac_scale_onehot), .test_tone_en(test_tone_en),
		.test_tone_rate(test_tone_rate), .test_tone_depth(test_tone_depth),
		.serial_one_bit_only(serial_one_bit_only));
	ddsm_host_model i_host (.clock(clock), .reset_n(reset_n), .profile_req(profile_req),
		.pd_req(pd_req), .xtal_req(xtal_req), .serial_req(serial_req),
		.sync_clk_pin(sync_clk_pin), .profile_pin(profile_pin), .power_down_pin(power_down_pin),
		.clk_mode_sel_pin(clk_mode_sel_pin), .serial_data_pin(serial_data_pin));
	task automatic end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one access; read data taken at the edge where waitrequest is seen low
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] data);
		int n;
		n = 0;
		@(posedge clock);
		address <= {idx, 2'h0};
		writedata <= data;
		read <= !wr;
		write <= wr;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (n >= 50) miscompares++;
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		repeat (3) @(posedge clock);
	endtask
	task automatic rcheck(input logic [5:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		cmp("readdata", exp, rd);
	endtask
	task automatic pins(input logic [3:0] p, input int hold);
		profile_req <= p;
		repeat (hold) @(posedge clock);
	endtask
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		end_sim;
	end
	initial begin
		{reset_n, read, write, pd_req, xtal_req} = 5'h0;
		{address, writedata, profile_req, serial_req} = 47'h0;
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		rcheck(6'h01, 32'h0);
		cmp("cp_sel", 32'h0, 32'(clk_cfg.cp_sel));
		bus(1'b1, 6'h3f, 32'hffff_ffff);
		rcheck(6'h3f, 32'h0);
		$display("reset and unmapped done");
		bus(1'b1, 6'h00, 32'h0); // aux channels off
		bus(1'b1, 6'h19, 32'h1234_5678);
		bus(1'b1, 6'h1a, 32'h0000_f2a5);
		bus(1'b1, 6'h01, 32'h0000_0004);
		cmp("tone_en", 32'h1, 32'(test_tone_en));
		cmp("tone_rate", 32'h1234_5678, test_tone_rate);
		cmp("tone_depth", 32'h2a5, 32'(test_tone_depth));
		$display("test tone done");
		foreach (mults[i]) begin
			bus(1'b1, 6'h01, {8'h0, i[0], mults[i], i[1:0], 16'h0}); // sweep clear
			exp_en = mults[i] >= 5'h04 && mults[i] <= 5'h14;
			cmp("pll_en", 32'(exp_en), 32'(clk_cfg.pll_en));
			cmp("pll_mult", 32'(exp_en ? mults[i] : 5'h01), 32'(clk_cfg.pll_mult));
			cmp("vco_high", 32'(i[0]), 32'(clk_cfg.vco_high));
			cmp("cp_sel", 32'(i[1:0]), 32'(clk_cfg.cp_sel));
		end
		xtal_req <= 1'b1;
		repeat (8) @(posedge clock);
		cmp("xtal_en", 32'h1, 32'(clk_cfg.xtal_en));
		xtal_req <= 1'b0;
		repeat (8) @(posedge clock);
		cmp("xtal_en", 32'h0, 32'(clk_cfg.xtal_en));
		$display("clock config done");
		foreach (dac_exp[i]) begin
			bus(1'b1, 6'h03, (32'(i) << 22) | (32'(i) << 8));
			cmp("dac_scale", 32'(dac_exp[i]), 32'(dac_scale_onehot));
			cmp("mod_type", 32'(i), 32'(mod_type));
		end
		bus(1'b1, 6'h03, 32'h0000_00a0);
		cmp("power_down", 32'ha, 32'(power_down));
		bus(1'b1, 6'h03, 32'h0000_0050);
		cmp("power_down", 32'h5, 32'(power_down));
		pd_req <= 1'b1;
		bus(1'b1, 6'h01, 32'h0);
		cmp("power_down", 32'h7, 32'(power_down));
		bus(1'b1, 6'h01, 32'h40);
		cmp("power_down", 32'hf, 32'(power_down));
		pd_req <= 1'b0;
		$display("power-down done");
		bus(1'b1, 6'h03, 32'h0080_0000);
		bus(1'b1, 6'h01, 32'h0000_1300);
		bus(1'b1, 6'h04, 32'hf000_0000);
		for (int k = 1; k < 16; k++) bus(1'b1, 6'(9 + k), {28'h1000_000, 4'(k)});
		foreach (sel[i]) begin
			pins(sel[i], 24);
			cmp("freq", (sel[i] == 4'h0) ? 32'hf000_0000 : {28'h1000_000, sel[i]},
				primary_word.freq);
		end
		bus(1'b1, 6'h0e, 32'h8003_ffff);
		bus(1'b1, 6'h03, 32'h00c0_0000);
		pins(4'h5, 24);
		cmp("phase", 32'h2000, 32'(primary_word.phase));
		bus(1'b1, 6'h03, 32'h0040_0000);
		cmp("amp", 32'h200, 32'(primary_word.amp));
		$display("profiles done");
		bus(1'b1, 6'h03, 32'h0080_0000);
		bus(1'b1, 6'h06, 32'h20);
		bus(1'b1, 6'h07, 32'h0);
		bus(1'b1, 6'h01, 32'h0000_1a00);
		pins(4'h8, 90);
		rcheck(6'h1b, 32'h0);
		pins(4'h0, 90);
		rcheck(6'h1b, 32'h20);
		bus(1'b1, 6'h01, 32'h0000_0c00);
		cmp("one_bit", 32'h1, 32'(serial_one_bit_only));
		bus(1'b1, 6'h01, 32'h0000_1a00);
		cmp("one_bit", 32'h0, 32'(serial_one_bit_only));
		$display("ramp done");
		end_sim;
	end
endmodule
